// ===== core/saux_consts.vh
// Constants for the sink auxiliary channel and configuration access block
`ifndef SAUX_CONSTS_VH
`define SAUX_CONSTS_VH
`define SAUX_CLK_HZ 10000000
`define SAUX_BIT_RATE_HZ 1000000
`define SAUX_CFG_BASE 12'h100
`define SAUX_CFG_TOP 12'h11F
`define SAUX_CFG_MST 12'h111
`define SAUX_STAT_BIT 12'h200
`define SAUX_STAT_FIELD 12'h202
`define SAUX_MST_EN_BIT 0
`define SAUX_UP_REQ_BIT 1
`define SAUX_UPSTREAM_BIT 2
`define SAUX_CFG_RESET 8'h00
`define SAUX_FIFO_WIDTH 8
`define SAUX_FIFO_DEPTH 16
`define SAUX_FIFO_AW 4
`endif

// ===== core/saux_fifo.v
// Synchronous FIFO with valid/ready on both sides
`timescale 1ns/1ps
`default_nettype none
module saux_fifo #(
  parameter WIDTH = 8,
  parameter DEPTH = 16,
  parameter AW = 4
) (
  input wire i_clk, // Clock
  input wire i_reset, // Synchronous reset, active high
  input wire i_wr_valid, // Write side has a word
  output wire o_wr_ready, // FIFO can take a word
  input wire [WIDTH-1:0] i_wr_data, // Word to store
  output wire o_rd_valid, // FIFO holds a word
  input wire i_rd_ready, // Drain side takes the word
  output wire [WIDTH-1:0] o_rd_data // Oldest word
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0] wr_ptr;
  reg [AW-1:0] rd_ptr;
  reg [AW:0] count;
  wire do_wr;
  wire do_rd;

  assign o_wr_ready = (count != DEPTH[AW:0]);
  assign o_rd_valid = (count != {(AW+1){1'b0}});
  assign o_rd_data = mem[rd_ptr];
  assign do_wr = i_wr_valid && o_wr_ready;
  assign do_rd = i_rd_ready && o_rd_valid;

  always @(posedge i_clk)
  begin
    if (do_wr)
    begin
      mem[wr_ptr] <= i_wr_data;
    end
  end

  always @(posedge i_clk)
  begin
    if (i_reset)
    begin
      wr_ptr <= {AW{1'b0}};
      rd_ptr <= {AW{1'b0}};
      count <= {(AW+1){1'b0}};
    end
    else
    begin
      if (do_wr)
      begin
        wr_ptr <= (wr_ptr == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}}
                  : wr_ptr + 1'b1;
      end
      if (do_rd)
      begin
        rd_ptr <= (rd_ptr == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}}
                  : rd_ptr + 1'b1;
      end
      if (do_wr && !do_rd)
      begin
        count <= count + 1'b1;
      end
      else if (do_rd && !do_wr)
      begin
        count <= count - 1'b1;
      end
    end
  end
endmodule
`default_nettype wire

// ===== core/saux_top.v
// Sink auxiliary channel coder and configuration data access
// Notes on behaviour
// R01 - Aux traffic both ways is Manchester-II coded at one megabit per second.
// R02 - Aux timing comes from the bus clock, an integer multiple of 1 MHz.
// R03 - Configuration values pass synchronizing stages before core-side use.
// R04 - Configuration registers are read and written on the bus clock.
// R05 - Single-bit status read mid-change returns old or new value.
// R06 - Lock freezes multi-bit status while its read is in progress.
// R07 - Multi-bit configuration writes flip a toggle; core refreshes copies.
// R08 - I2C over aux is driven by an outside controller, pass-through only.
// R09 - Address 0x111 bits 0,1,2: multistream, up-request, upstream-source.
// R10 - Bus reset holds aux and configuration logic in reset.
// R11 - Count clock/1MHz cycles per cell; opposite level each half cell.
`timescale 1ns/1ps
`default_nettype none
`include "saux_consts.vh"
module saux_top #(
  parameter CLK_HZ = `SAUX_CLK_HZ,
  parameter FIFO_DEPTH = `SAUX_FIFO_DEPTH,
  parameter FIFO_AW = `SAUX_FIFO_AW
) (
  input wire i_clk, // Bus clock, also aux bit timing
  input wire i_reset, // Synchronous reset, active high
  input wire i_cfg_wr, // Configuration write strobe
  input wire i_cfg_rd, // Configuration read strobe
  input wire [11:0] i_cfg_addr, // Configuration address
  input wire [7:0] i_cfg_wdata, // Configuration write data
  output reg [7:0] o_cfg_rdata, // Configuration read data
  output reg o_cfg_rvalid, // Read data valid pulse
  input wire i_stat_bit, // Single-bit status from the core
  input wire [7:0] i_stat_field, // Multi-bit status from the core
  output reg o_stat_lock, // Status field frozen for a read
  output reg o_cfg_toggle, // Flips on each configuration write to 0x100-0x11F
  output reg o_mst_en, // Multistream enable, core copy
  output reg o_up_req_en, // Up-request enable, core copy
  output reg o_upstream_source_indication, // Upstream is source, core copy
  input wire i_tx_valid, // Reply byte offered
  output wire o_tx_ready, // Reply FIFO has room
  input wire [7:0] i_tx_data, // Reply byte
  output wire o_tx_busy, // Coder is sending
  input wire i_aux_data_in, // Aux line level received
  output reg o_aux_data_out, // Aux line level driven
  output reg o_aux_data_enable_n, // Aux driver enable, low drives
  output reg o_rx_valid, // Received byte pulse
  output reg [7:0] o_rx_data // Received byte
);
  // R02 cell length from the bus clock
  localparam integer CELL = CLK_HZ / `SAUX_BIT_RATE_HZ;
  localparam integer HALF = CELL / 2;
  localparam integer MID_MIN = (CELL * 3) / 4;
  localparam integer GAP = CELL * 2;
  localparam [15:0] CELL_LAST = CELL[15:0] - 16'h0001;
  localparam [15:0] HALF_CNT = HALF[15:0];
  localparam [15:0] MID_CNT = MID_MIN[15:0];
  localparam [15:0] GAP_CNT = GAP[15:0];
  localparam ST_IDLE = 1'b0;
  localparam ST_SEND = 1'b1;
  // Configuration space, bus clock domain
  reg [7:0] cfg_mem [0:31];
  reg [7:0] mst_reg, stat_snap, next_rdata;
  reg rd_pend;
  reg [11:0] rd_addr;
  reg cfg_tgl_s1, cfg_tgl_s2, cfg_tgl_s3;
  reg [2:0] mst_s1, mst_s2;
  wire cfg_hit_wr;
  wire [4:0] wr_idx, rd_idx;
  integer k;
  assign wr_idx = i_cfg_addr[4:0];
  assign rd_idx = rd_addr[4:0];
  assign cfg_hit_wr = i_cfg_wr && (i_cfg_addr >= `SAUX_CFG_BASE)
                      && (i_cfg_addr <= `SAUX_CFG_TOP);
  // R04 bus-clock register writes
  always @(posedge i_clk)
  begin
    if (i_reset)
    begin
      for (k = 0; k < 32; k = k + 1)
      begin
        cfg_mem[k] <= `SAUX_CFG_RESET;
      end
      mst_reg <= `SAUX_CFG_RESET;
      o_cfg_toggle <= 1'b0;
    end
    else if (cfg_hit_wr)
    begin
      cfg_mem[wr_idx] <= i_cfg_wdata;
      if (i_cfg_addr == `SAUX_CFG_MST)
      begin
        mst_reg <= i_cfg_wdata;
      end
      // R07 toggle marks new configuration
      o_cfg_toggle <= ~o_cfg_toggle;
    end
  end
  // R06 status snapshot frozen while locked
  always @(posedge i_clk)
  begin
    if (i_reset)
    begin
      stat_snap <= 8'h00;
    end
    else if (!o_stat_lock)
    begin
      stat_snap <= i_stat_field;
    end
  end
  always @*
  begin
    next_rdata = 8'h00;
    if (rd_addr == `SAUX_STAT_FIELD)
    begin
      next_rdata = stat_snap;
    end
    else if (rd_addr == `SAUX_STAT_BIT)
    begin
      // R05 either old or new level
      next_rdata = {7'h00, i_stat_bit};
    end
    else if ((rd_addr >= `SAUX_CFG_BASE) && (rd_addr <= `SAUX_CFG_TOP))
    begin
      next_rdata = cfg_mem[rd_idx];
    end
  end
  // Reads take two edges so the lock can close first
  always @(posedge i_clk)
  begin
    if (i_reset)
    begin
      rd_pend <= 1'b0;
      rd_addr <= 12'h000;
      o_stat_lock <= 1'b0;
      o_cfg_rdata <= 8'h00;
      o_cfg_rvalid <= 1'b0;
    end
    else
    begin
      o_cfg_rvalid <= 1'b0;
      if (rd_pend)
      begin
        rd_pend <= 1'b0;
        o_cfg_rdata <= next_rdata;
        o_cfg_rvalid <= 1'b1;
        // R06 lock released once data taken
        o_stat_lock <= 1'b0;
      end
      else if (i_cfg_rd)
      begin
        rd_pend <= 1'b1;
        rd_addr <= i_cfg_addr;
        // R06 lock closes at read start
        o_stat_lock <= (i_cfg_addr == `SAUX_STAT_FIELD);
      end
    end
  end
  // Core-side copies; the value reaches mst_s2 on the same edge the toggle reaches cfg_tgl_s2
  always @(posedge i_clk)
  begin
    if (i_reset)
    begin
      cfg_tgl_s1 <= 1'b0;
      cfg_tgl_s2 <= 1'b0;
      cfg_tgl_s3 <= 1'b0;
      mst_s1 <= 3'h0;
      mst_s2 <= 3'h0;
      o_mst_en <= 1'b0;
      o_up_req_en <= 1'b0;
      o_upstream_source_indication <= 1'b0;
    end
    else
    begin
      // R03 two stages before core use
      cfg_tgl_s1 <= o_cfg_toggle;
      cfg_tgl_s2 <= cfg_tgl_s1;
      cfg_tgl_s3 <= cfg_tgl_s2;
      mst_s1 <= mst_reg[2:0];
      mst_s2 <= mst_s1;
      // R07 refresh copies on toggle
      if (cfg_tgl_s2 != cfg_tgl_s3)
      begin
        // R09 decode of address 0x111
        o_mst_en <= mst_s2[`SAUX_MST_EN_BIT];
        o_up_req_en <= mst_s2[`SAUX_UP_REQ_BIT];
        o_upstream_source_indication <= mst_s2[`SAUX_UPSTREAM_BIT];
      end
    end
  end
  // Reply FIFO in front of the coder
  wire fifo_valid, fifo_pop, cell_end;
  wire [7:0] fifo_data;
  reg tx_state;
  reg [15:0] tx_cnt;
  reg [2:0] tx_bit;
  reg [7:0] tx_shift;
  assign cell_end = (tx_cnt == CELL_LAST);
  assign fifo_pop = fifo_valid
                    && ((tx_state == ST_IDLE)
                    || (cell_end && (tx_bit == 3'd7)));
  assign o_tx_busy = (tx_state == ST_SEND);
  saux_fifo #(
    .WIDTH(`SAUX_FIFO_WIDTH),
    .DEPTH(FIFO_DEPTH),
    .AW(FIFO_AW)
  ) u_fifo (
    .i_clk(i_clk),
    .i_reset(i_reset),
    .i_wr_valid(i_tx_valid),
    .o_wr_ready(o_tx_ready),
    .i_wr_data(i_tx_data),
    .o_rd_valid(fifo_valid),
    .i_rd_ready(fifo_pop),
    .o_rd_data(fifo_data)
  );
  // Coder: a one is high then low, a zero low then high
  always @(posedge i_clk)
  begin
    if (i_reset)
    begin
      tx_state <= ST_IDLE;
      tx_cnt <= 16'h0000;
      tx_bit <= 3'd0;
      tx_shift <= 8'h00;
      o_aux_data_out <= 1'b0;
      o_aux_data_enable_n <= 1'b1;
    end
    else
    begin
      case (tx_state)
        ST_IDLE:
        begin
          if (fifo_valid)
          begin
            tx_state <= ST_SEND;
            tx_shift <= fifo_data;
            tx_bit <= 3'd0;
            o_aux_data_enable_n <= 1'b0;
            // R01 first half carries the bit
            o_aux_data_out <= fifo_data[7];
          end
        end
        ST_SEND:
        begin
          // R11 cell counter from bus clock
          if (cell_end)
          begin
            tx_cnt <= 16'h0000;
            if (tx_bit == 3'd7)
            begin
              tx_bit <= 3'd0;
              if (fifo_valid)
              begin
                tx_shift <= fifo_data;
                o_aux_data_out <= fifo_data[7];
              end
              else
              begin
                tx_state <= ST_IDLE;
                o_aux_data_enable_n <= 1'b1;
                o_aux_data_out <= 1'b0;
              end
            end
            else
            begin
              tx_bit <= tx_bit + 3'd1;
              tx_shift <= {tx_shift[6:0], 1'b0};
              o_aux_data_out <= tx_shift[6];
            end
          end
          else
          begin
            tx_cnt <= tx_cnt + 16'h0001;
            // R11 opposite level in second half
            if (tx_cnt == HALF_CNT - 16'h0001)
            begin
              o_aux_data_out <= ~tx_shift[7];
            end
          end
        end
        default:
        begin
          tx_state <= ST_IDLE;
        end
      endcase
    end
  end
  // Decoder: only mid-cell edges carry data, boundary edges are skipped
  reg rx_prev;
  reg [15:0] rx_cnt;
  reg [2:0] rx_bits;
  reg [7:0] rx_shift;
  wire rx_edge, rx_mid;
  assign rx_edge = (i_aux_data_in != rx_prev);
  assign rx_mid = rx_edge && (rx_cnt >= MID_CNT);
  always @(posedge i_clk)
  begin
    if (i_reset)
    begin
      rx_prev <= 1'b0;
      rx_cnt <= GAP_CNT;
      rx_bits <= 3'd0;
      rx_shift <= 8'h00;
      o_rx_valid <= 1'b0;
      o_rx_data <= 8'h00;
    end
    else
    begin
      o_rx_valid <= 1'b0;
      rx_prev <= i_aux_data_in;
      // Our own reply is not decoded back
      if (!o_aux_data_enable_n)
      begin
        rx_cnt <= GAP_CNT;
        rx_bits <= 3'd0;
      end
      else if (rx_mid)
      begin
        // R01 falling mid-cell edge is a one
        rx_cnt <= 16'h0000;
        rx_shift <= {rx_shift[6:0], ~i_aux_data_in};
        rx_bits <= rx_bits + 3'd1;
        if (rx_bits == 3'd7)
        begin
          o_rx_valid <= 1'b1;
          o_rx_data <= {rx_shift[6:0], ~i_aux_data_in};
        end
      end
      else if (rx_cnt < GAP_CNT)
      begin
        rx_cnt <= rx_cnt + 16'h0001;
      end
      else
      begin
        // Line idle too long: drop a partial byte
        rx_bits <= 3'd0;
      end
    end
  end
endmodule
`default_nettype wire

// ===== dv/saux_top_chk.sv
// Assertion checker bound to saux_top
`timescale 1ns/1ps
`default_nettype none
module saux_chk (
  input wire i_clk,
  input wire i_reset,
  input wire i_cfg_wr,
  input wire i_cfg_rd,
  input wire [11:0] i_cfg_addr,
  input wire [7:0] i_cfg_wdata,
  input wire [7:0] o_cfg_rdata,
  input wire o_cfg_rvalid,
  input wire [7:0] i_stat_field,
  input wire o_stat_lock,
  input wire o_cfg_toggle,
  input wire o_mst_en,
  input wire o_up_req_en,
  input wire o_upstream_source_indication,
  input wire o_tx_busy,
  input wire o_aux_data_out,
  input wire o_aux_data_enable_n,
  input wire o_rx_valid
);
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (i_reset);
  wire cw = i_cfg_wr && i_cfg_addr >= 12'h100 && i_cfg_addr <= 12'h11F;
  wire st = i_cfg_rd && i_cfg_addr == 12'h202;
  rd_answer_a: assert property (
    i_cfg_rd && !$past(i_cfg_rd) |-> ##2 o_cfg_rvalid)
    else $error("read answer missing");
  rv_pulse_a: assert property (o_cfg_rvalid |=> !o_cfg_rvalid)
    else $error("read valid too long");
  lock_window_a: assert property (
    st && !$past(i_cfg_rd) |=> o_stat_lock ##1 !o_stat_lock)
    else $error("lock window wrong");
  snap_hold_a: assert property (
    st && !$past(i_cfg_rd) |-> ##2 o_cfg_rdata == $past(i_stat_field, 2))
    else $error("status field not frozen");
  tog_flip_a: assert property (
    cw |=> o_cfg_toggle != $past(o_cfg_toggle))
    else $error("toggle did not flip");
  tog_hold_a: assert property (!cw |=> $stable(o_cfg_toggle))
    else $error("toggle moved");
  mst_copy_a: assert property (i_cfg_wr && i_cfg_addr == 12'h111 |-> ##4
    {5'h00, o_upstream_source_indication, o_up_req_en, o_mst_en} ==
    ($past(i_cfg_wdata, 4) & 8'h07))
    else $error("core copy wrong");
  cell_half_a: assert property ($fell(o_aux_data_enable_n) |=>
    $stable(o_aux_data_out)[*4] ##1 $changed(o_aux_data_out))
    else $error("half cell length wrong");
  drive_busy_a: assert property (!o_aux_data_enable_n |-> o_tx_busy)
    else $error("driving while idle");
  rx_pulse_a: assert property (o_rx_valid |=> !o_rx_valid)
    else $error("rx valid too long");
endmodule
bind saux_top saux_chk chk (.i_clk, .i_reset, .i_cfg_wr, .i_cfg_rd,
  .i_cfg_addr, .i_cfg_wdata, .o_cfg_rdata, .o_cfg_rvalid, .i_stat_field,
  .o_stat_lock, .o_cfg_toggle, .o_mst_en, .o_up_req_en,
  .o_upstream_source_indication, .o_tx_busy, .o_aux_data_out,
  .o_aux_data_enable_n, .o_rx_valid);
`default_nettype wire

// ===== dv/saux_src_model.sv
// Aux source model sending Manchester-II coded bytes
`timescale 1ns/1ps
`default_nettype none
module saux_src_model (
  input wire i_clk, // Bus clock
  output reg o_line // Aux line level
);
  integer k;
  initial o_line = 1'b0;
  // no I2C traffic here; an outside controller owns that port
  // ten-cycle cells, one is high then low
  task send(input [7:0] b, input integer n);
    begin
      // Rest at first half level; a stray edge ages out as idle
      o_line = b[7];
      repeat (25) @(posedge i_clk);
      for (k = 7; k > 7 - n; k = k - 1)
      begin
        #1 o_line = b[k];
        repeat (5) @(posedge i_clk);
        #1 o_line = ~b[k];
        repeat (5) @(posedge i_clk);
      end
      // Released line does not keep its last level
      #1 o_line = ~o_line;
    end
  endtask
endmodule
`default_nettype wire

// ===== dv/saux_top_bench.sv
// Self-checking bench for saux_top
`timescale 1ns/1ps
`default_nettype none
`include "saux_consts.vh"
module saux_top_bench;
  reg i_clk, i_reset, i_cfg_wr, i_cfg_rd, i_stat_bit, i_tx_valid, t;
  reg [11:0] i_cfg_addr;
  reg [7:0] i_cfg_wdata, i_stat_field, i_tx_data, v, got;
  wire [7:0] o_cfg_rdata, o_rx_data;
  wire o_cfg_rvalid, o_stat_lock, o_cfg_toggle, o_mst_en, o_up_req_en;
  wire o_upstream_source_indication, o_tx_ready, o_tx_busy, line;
  wire o_aux_data_out, o_aux_data_enable_n, o_rx_valid;
  integer error_cnt, n_checks, seed, i, n;
  reg [7:0] cfg [0:31];
  reg [7:0] txq [$];
  reg [7:0] rxq [$];
  saux_top uut (.i_clk, .i_reset, .i_cfg_wr, .i_cfg_rd, .i_cfg_addr,
    .i_cfg_wdata, .o_cfg_rdata, .o_cfg_rvalid, .i_stat_bit, .i_stat_field,
    .o_stat_lock, .o_cfg_toggle, .o_mst_en, .o_up_req_en,
    .o_upstream_source_indication, .i_tx_valid, .o_tx_ready, .i_tx_data,
    .o_tx_busy, .i_aux_data_in(line), .o_aux_data_out,
    .o_aux_data_enable_n, .o_rx_valid, .o_rx_data);
  saux_src_model src (.i_clk, .o_line(line));
  task chk(input [7:0] seen, input [7:0] exp, input [47:0] nm);
    begin
      n_checks = n_checks + 1;
      if (seen !== exp)
      begin
        error_cnt = error_cnt + 1;
        $display("[FAIL] %0s expected %h seen %h", nm, exp, seen);
      end
    end
  endtask
  task print_verdict;
    begin
      $display("checks %0d errors %0d", n_checks, error_cnt);
      if (error_cnt == 0 && n_checks > 0)
        $display("TEST PASSED");
      else
        $display("TEST FAILED");
      $finish;
    end
  endtask
  task wr(input [11:0] a, input [7:0] d);
    begin
      i_cfg_wr = 1'b1;
      i_cfg_addr = a;
      i_cfg_wdata = d;
      @(posedge i_clk);
      #1 i_cfg_wr = 1'b0;
      if (a >= 12'h100 && a <= 12'h11F) cfg[a[4:0]] = d;
      repeat (5) @(posedge i_clk);
      #1;
    end
  endtask
  task rd(input [11:0] a);
    begin
      i_cfg_rd = 1'b1;
      i_cfg_addr = a;
      @(posedge i_clk);
      #1 i_cfg_rd = 1'b0;
      if (a == 12'h202) chk(o_stat_lock, 1, "lock");
      // Status moves under the lock; read must keep the snapshot
      i_stat_field = ~i_stat_field;
      @(posedge i_clk);
      #1 chk(o_cfg_rvalid, 1, "rvalid");
      got = o_cfg_rdata;
    end
  endtask
  initial
  begin : txmon
    integer b;
    reg [7:0] q;
    reg h;
    forever
    begin
      @(negedge i_clk);
      while (o_aux_data_enable_n === 1'b0)
      begin
        for (b = 0; b < 8; b = b + 1)
        begin
          repeat (2) @(negedge i_clk);
          h = o_aux_data_out;
          repeat (5) @(negedge i_clk);
          chk(o_aux_data_out, {7'h00, ~h}, "half");
          q = {q[6:0], h};
          repeat (3) @(negedge i_clk);
        end
        chk(q, txq.pop_front(), "txbyte");
      end
    end
  end
  always @(negedge i_clk)
    if (o_rx_valid === 1'b1 && rxq.size() == 0)
      chk(o_rx_valid, 0, "rxnone");
    else if (o_rx_valid === 1'b1)
      chk(o_rx_data, rxq.pop_front(), "rxbyte");
  initial
  begin
    i_clk = 1'b0;
    forever #50 i_clk = ~i_clk;
  end
  initial
  begin
    #1000000;
    error_cnt = error_cnt + 1;
    print_verdict;
  end
  initial
  begin
    error_cnt = 0;
    n_checks = 0;
    seed = 53322;
    {i_cfg_wr, i_cfg_rd, i_stat_bit, i_tx_valid} = 4'h0;
    {i_cfg_addr, i_cfg_wdata, i_stat_field, i_tx_data} = 36'h0;
    for (i = 0; i < 32; i = i + 1) cfg[i] = `SAUX_CFG_RESET;
    i_reset = 1'b1;
    repeat (2) @(posedge i_clk);
    #1 i_reset = 1'b0;
    chk(o_aux_data_enable_n, 1, "en_n");
    chk(o_tx_ready, 1, "ready");
    for (i = 0; i < 8; i = i + 1)
    begin
      t = o_cfg_toggle;
      v = $random(seed);
      wr(12'h111, {v[7:3], i[2:0]});
      chk(o_cfg_toggle, {7'h00, ~t}, "toggle");
      chk({o_upstream_source_indication, o_up_req_en, o_mst_en}, i[2:0],
        "copy");
      rd(12'h111);
      chk(got, cfg[17], "cfg");
    end
    for (i = 0; i < 2; i = i + 1)
    begin
      wr(i ? 12'h11F : 12'h100, $random(seed));
      rd(i ? 12'h11F : 12'h100);
      chk(got, cfg[i ? 31 : 0], "edge");
      i_stat_bit = i[0];
      rd(12'h200);
      chk(got, {7'h00, i_stat_bit}, "sbit");
    end
    t = o_cfg_toggle;
    wr(12'h120, 8'hA5);
    chk(o_cfg_toggle, {7'h00, t}, "toggle");
    rd(12'h120);
    chk(got, 8'h00, "unmap");
    i_stat_field = $random(seed);
    v = i_stat_field;
    rd(12'h202);
    chk(got, v, "sfield");
    n = 0;
    i_tx_valid = 1'b1;
    i_tx_data = $random(seed);
    for (i = 0; i < 20; i = i + 1)
    begin
      t = o_tx_ready;
      @(posedge i_clk);
      #1;
      if (t === 1'b1)
      begin
        txq.push_back(i_tx_data);
        n = n + 1;
        i_tx_data = $random(seed);
      end
    end
    chk(n, `SAUX_FIFO_DEPTH + 1, "fill");
    chk(o_tx_busy, 1, "busy");
    for (i = 0; o_tx_ready !== 1'b1 && i < 200; i = i + 1)
      @(posedge i_clk) #1;
    @(posedge i_clk);
    #1 txq.push_back(i_tx_data);
    i_tx_valid = 1'b0;
    for (i = 0; txq.size() > 0 && i < 3000; i = i + 1)
      @(posedge i_clk) #1;
    repeat (2) @(posedge i_clk);
    #1 chk(o_aux_data_enable_n, 1, "en_n");
    chk(o_tx_busy, 0, "busy");
    chk(txq.size(), 0, "txleft");
    src.send(8'hA5, 4);
    for (i = 0; i < 5; i = i + 1)
    begin
      repeat (40) @(posedge i_clk);
      #1 v = $random(seed);
      rxq.push_back(v);
      src.send(v, 8);
    end
    repeat (40) @(posedge i_clk);
    #1 chk(rxq.size(), 0, "rxleft");
    print_verdict;
  end
endmodule
`default_nettype wire
